//--- verilog/ubde_pkg.sv
// Purpose: shared constants and carriers for the descriptor engine
// Assumes: one clock, APB register access, 32-bit data
// Notes: local RAM holds the descriptor table and packet buffers
package ubde_pkg;
  // ------------------------------------------------------------
  // local RAM and descriptor layout
  // ------------------------------------------------------------
  localparam int RAM_AW = 8;                    // local RAM index width
  localparam int RAM_DEPTH = 256;               // local RAM bytes
  localparam logic [7:0] DESC_BYTES = 8'h03;    // bytes per descriptor
  localparam logic [7:0] DESC_CTRL = 8'h00;     // ownership, toggle, pid
  localparam logic [7:0] DESC_BC = 8'h01;       // byte count field
  localparam logic [7:0] DESC_BASE = 8'h02;     // buffer base field
  localparam int OWN_BIT = 7;
  localparam int TOG_BIT = 6;
  localparam int PID_LSB = 2;
  localparam int DTS_BIT = 3;
  localparam int STALL_BIT = 2;
  localparam logic [3:0] BUF_LOW = 4'h0;        // buffers are 16-byte aligned
  // ------------------------------------------------------------
  // token codes and packet limits
  // ------------------------------------------------------------
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_LAT = 4'hf;        // latency error code, never written
  localparam logic [6:0] MAXP_LIMIT = 7'h40;    // 64-byte ceiling
  localparam int NUM_EP = 7;
  // ------------------------------------------------------------
  // register map (byte addresses); RAM window lies below REG_BASE
  // ------------------------------------------------------------
  localparam logic [11:0] REG_BASE = 12'h400;
  localparam logic [11:0] A_STATUS = 12'h400;
  localparam logic [11:0] A_INTF = 12'h404;
  localparam logic [11:0] A_INTM = 12'h408;
  localparam logic [11:0] A_ERRF = 12'h40c;
  localparam logic [11:0] A_ERRM = 12'h410;
  localparam logic [11:0] A_MAXP = 12'h414;
  localparam logic [11:0] A_ISO = 12'h418;
  localparam int INT_DONE = 0;                  // token done
  localparam int INT_ERR = 1;                   // unmasked error summary
  localparam int INT_STALL = 2;                 // stall handshake sent
  localparam int ERR_TMO = 0;                   // timeout error
  localparam int ERR_OVF = 1;                   // buffer overflow error
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} ubde_hs_t;
  typedef struct packed {logic [3:0] pid; logic [2:0] ep; logic odd;} ubde_tok_t;
  typedef struct packed {logic valid; logic [7:0] data; logic eop;} ubde_rx_t;
  typedef struct packed {logic [7:0] data; logic last; logic zlp;} ubde_tx_t;

  // descriptor table offset of endpoint, direction and buffer half
  function automatic logic [7:0] desc_addr(input ubde_tok_t t);
    logic [4:0] idx;
    idx = {t.ep, t.pid == PID_IN, t.odd};
    return 8'({3'b000, idx}) * DESC_BYTES;
  endfunction
endpackage

//--- verilog/ubde_top.sv
// Purpose: buffer-descriptor engine between serial engine and local RAM
// Assumes: serial engine logic runs on CLK_IN; APB slave with no waits
// Notes: one RAM port, APB RAM access takes it first and stalls the engine
// Operation
// - stall bit on an owned descriptor: STALL, descriptor untouched
// - receive writes back received byte count
// - packets limited to 64 bytes
// - buffer address is base times sixteen
// - buffer base field never written
// - descriptor address from endpoint, direction, half
// - move data only when device owns
// - write-back clears ownership bit
// - status register and token-done after write-back
// - latency overrun: NAK/timeout, timeout flag
// - interrupt only through enable masks
// - latency overrun: no write-back, no done
// - oversized non-isochronous packet still ACKed
// - oversized packet clipped to max size
// - oversized packet sets overflow flag
// - oversize: normal pid, count equals max
// - unowned descriptor fields are ignored
// - token pid written into descriptor
// - descriptor is three consecutive bytes
//
// Chosen here: the register addresses and the APB interface to the registers.
module ubde_top #(
  parameter int NEP = ubde_pkg::NUM_EP
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic TOK_VALID_IN,
  input wire ubde_pkg::ubde_tok_t TOK_IN,
  output logic TOK_READY_OUT,
  input wire ubde_pkg::ubde_rx_t RX_IN,
  output logic TX_VALID_OUT,
  output ubde_pkg::ubde_tx_t TX_OUT,
  input wire logic TX_READY_IN,
  output logic HS_VALID_OUT,
  output ubde_pkg::ubde_hs_t HS_CODE_OUT,
  output logic IRQ_OUT
);
  import ubde_pkg::*;

  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_F0, S_F1, S_F2, S_DEC, S_RX, S_TXRD, S_TXOUT, S_END, S_WB1, S_WB0
  } ubde_st_t;
  ubde_st_t st_q;
  logic [7:0] ram_q [RAM_DEPTH];     // descriptor table and buffers
  ubde_tok_t tok_q;                  // token being served
  logic [7:0] desc_q;                // descriptor offset
  logic own_q, stall_q, tog_q;       // fetched control bits
  logic [7:0] bc_q;                  // fetched byte count
  logic [5:0] base_q;                // fetched buffer base
  logic [6:0] cnt_q;                 // bytes moved so far
  logic ovr_q, ovs_q, eop_q;         // overrun, oversize, end seen
  logic rxh_v_q;                     // receive holding byte valid
  logic [7:0] rxh_d_q;
  ubde_tx_t tx_q;
  logic [NEP-1:0] iso_q;             // isochronous endpoints
  logic [6:0] maxp_q;
  logic [2:0] intf_q, intm_q;
  logic [1:0] errf_q, errm_q;
  logic [4:0] stat_q;                // endpoint, direction, half
  logic hs_v_q;
  ubde_hs_t hs_q;

  // ------------------------------------------------------------
  // combinational decode
  // ------------------------------------------------------------
  logic apb_acc, apb_ram, apb_wr, gnt, dir_tx, iso, store;
  logic eng_we, rx_take;
  logic [7:0] eng_a, eng_wd, ram_rd, byte0;
  logic [9:0] buf_a;
  logic [2:0] intf_all;
  logic [RAM_AW-1:0] ram_a;

  assign apb_acc = PSEL_IN && PENABLE_IN;
  assign apb_ram = apb_acc && (PADDR_IN < REG_BASE);
  assign apb_wr = apb_acc && PWRITE_IN;
  // firmware wins the port; the engine waits, which is what can overrun it
  assign gnt = !apb_ram;
  assign dir_tx = (tok_q.pid == PID_IN);
  assign iso = iso_q[tok_q.ep];
  assign store = own_q && !stall_q && (cnt_q < maxp_q);
  assign buf_a = {base_q, BUF_LOW} + {3'b000, cnt_q};
  assign byte0 = {1'b0, tog_q, tok_q.pid, 2'b00};
  assign rx_take = (st_q == S_RX) && gnt && rxh_v_q;
  // error summary gated by error mask
  assign intf_all = {intf_q[INT_STALL], |(errf_q & errm_q), intf_q[INT_DONE]};

  // engine address and write data
  always_comb begin
    eng_a = desc_q;
    if (st_q == S_F1 || st_q == S_WB1) begin
      eng_a = desc_q + DESC_BC;
    end else if (st_q == S_F2) begin
      eng_a = desc_q + DESC_BASE;
    end else if (st_q == S_RX || st_q == S_TXRD) begin
      eng_a = buf_a[7:0];
    end
    // base byte is never a write target
    eng_we = gnt && ((rx_take && store) || (st_q == S_WB1 && !dir_tx) || st_q == S_WB0);
    if (st_q == S_WB0) begin
      eng_wd = byte0;
    end else if (st_q == S_WB1) begin
      eng_wd = {1'b0, cnt_q};
    end else begin
      eng_wd = rxh_d_q;
    end
  end

  assign ram_a = apb_ram ? PADDR_IN[RAM_AW+1:2] : eng_a[RAM_AW-1:0];
  assign ram_rd = ram_q[ram_a];

  // ------------------------------------------------------------
  // local RAM, one port
  // ------------------------------------------------------------
  // no reset: buffer contents are data, firmware initialises them
  always_ff @(posedge CLK_IN) begin
    if (apb_ram && PWRITE_IN) begin
      ram_q[ram_a] <= PWDATA_IN[7:0];
    end else if (eng_we) begin
      ram_q[ram_a] <= eng_wd;
    end
  end

  // ------------------------------------------------------------
  // receive holding byte
  // ------------------------------------------------------------
  // one byte of slack; a second byte before the first lands is an overrun
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      rxh_v_q <= 1'b0;
      rxh_d_q <= 8'h00;
      eop_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (st_q == S_IDLE) begin
      rxh_v_q <= 1'b0;
      eop_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (RX_IN.valid && !RX_IN.eop) begin
        rxh_d_q <= RX_IN.data;
        rxh_v_q <= 1'b1;
        if (rxh_v_q && !rx_take) begin
          ovr_q <= 1'b1;
        end
      end else if (rx_take) begin
        rxh_v_q <= 1'b0;
      end
      if (RX_IN.valid && RX_IN.eop) begin
        eop_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // descriptor engine
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      st_q <= S_IDLE;
      tok_q <= '0;
      desc_q <= 8'h00;
      {own_q, stall_q, tog_q} <= 3'b000;
      bc_q <= 8'h00;
      base_q <= 6'h00;
      cnt_q <= 7'h00;
      ovs_q <= 1'b0;
      tx_q <= '0;
      hs_v_q <= 1'b0;
      hs_q <= HS_NONE;
    end else begin
      hs_v_q <= 1'b0;
      unique case (st_q)
        S_IDLE: begin
          if (TOK_VALID_IN) begin
            tok_q <= TOK_IN;
            desc_q <= desc_addr(TOK_IN);
            cnt_q <= 7'h00;
            ovs_q <= 1'b0;
            st_q <= S_F0;
          end
        end
        S_F0: if (gnt) begin
          own_q <= ram_rd[OWN_BIT];
          tog_q <= ram_rd[TOG_BIT];
          stall_q <= ram_rd[STALL_BIT];
          st_q <= S_F1;
        end
        S_F1: if (gnt) begin
          bc_q <= ram_rd;
          st_q <= S_F2;
        end
        S_F2: if (gnt) begin
          base_q <= ram_rd[7:2];
          st_q <= S_DEC;
        end
        S_DEC: begin
          // unowned or stalled: no transmit at all
          if (dir_tx) begin
            st_q <= (own_q && !stall_q) ? S_TXRD : S_END;
          end else begin
            st_q <= S_RX;
          end
        end
        S_RX: begin
          // store owned bytes up to max size
          if (rx_take) begin
            if (store) begin
              cnt_q <= cnt_q + 7'h01;
            end else if (own_q && !stall_q) begin
              ovs_q <= 1'b1;
            end
          end
          if (eop_q && !rxh_v_q) begin
            st_q <= S_END;
          end
        end
        S_TXRD: if (gnt) begin
          // transmit length clipped to max size
          if (bc_q == 8'h00) begin
            tx_q <= '{data: 8'h00, last: 1'b1, zlp: 1'b1};
          end else begin
            tx_q <= '{data: ram_rd, last: 1'b0, zlp: 1'b0};
            if ({1'b0, cnt_q + 7'h01} == bc_q || cnt_q + 7'h01 == maxp_q) begin
              tx_q.last <= 1'b1;
            end
            cnt_q <= cnt_q + 7'h01;
          end
          st_q <= S_TXOUT;
        end
        S_TXOUT: if (TX_READY_IN) begin
          st_q <= tx_q.last ? S_END : S_TXRD;
        end
        S_END: begin
          hs_v_q <= 1'b1;
          st_q <= S_IDLE;
          if (own_q && stall_q) begin
            // stall counts only on an owned descriptor
            hs_q <= HS_STALL;
          end else if (!own_q) begin
            hs_q <= HS_NAK;
          end else if (ovr_q && !dir_tx) begin
            hs_q <= iso ? HS_NONE : HS_NAK;
          end else begin
            hs_q <= (iso || dir_tx) ? HS_NONE : HS_ACK;
            st_q <= S_WB1;
          end
        end
        S_WB1: if (gnt) begin
          st_q <= S_WB0;
        end
        S_WB0: if (gnt) begin
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  // flags are write-one-to-clear; a same-cycle hardware set wins
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      intf_q <= 3'b000;
      errf_q <= 2'b00;
      intm_q <= 3'b000;
      errm_q <= 2'b00;
      maxp_q <= MAXP_LIMIT;
      iso_q <= '0;
      stat_q <= 5'h00;
    end else begin
      if (apb_wr) begin
        unique case (PADDR_IN)
          A_INTF: intf_q <= intf_q & ~PWDATA_IN[2:0];
          A_ERRF: errf_q <= errf_q & ~PWDATA_IN[1:0];
          A_INTM: intm_q <= PWDATA_IN[2:0];
          A_ERRM: errm_q <= PWDATA_IN[1:0];
          A_MAXP: maxp_q <= (PWDATA_IN[6:0] > MAXP_LIMIT) ? MAXP_LIMIT : PWDATA_IN[6:0];
          A_ISO: iso_q <= PWDATA_IN[NEP-1:0];
          default: ;
        endcase
      end
      if (st_q == S_WB0 && gnt) begin
        stat_q <= {tok_q.ep, dir_tx, tok_q.odd};
        intf_q[INT_DONE] <= 1'b1;
      end
      if (st_q == S_END && own_q && stall_q) begin
        intf_q[INT_STALL] <= 1'b1;
      end
      if (st_q == S_END && own_q && !stall_q && !dir_tx) begin
        if (ovr_q) begin
          errf_q[ERR_TMO] <= 1'b1;
        end else if (ovs_q) begin
          errf_q[ERR_OVF] <= 1'b1;
        end
      end
    end
  end

  // read data mux
  always_comb begin
    PRDATA_OUT = 32'h0000_0000;
    PSLVERR_OUT = 1'b0;
    if (apb_ram) begin
      PRDATA_OUT = {24'h00_0000, ram_rd};
    end else if (apb_acc) begin
      unique case (PADDR_IN)
        A_STATUS: PRDATA_OUT = {27'h000_0000, stat_q};
        A_INTF: PRDATA_OUT = {29'h0000_0000, intf_all};
        A_INTM: PRDATA_OUT = {29'h0000_0000, intm_q};
        A_ERRF: PRDATA_OUT = {30'h0000_0000, errf_q};
        A_ERRM: PRDATA_OUT = {30'h0000_0000, errm_q};
        A_MAXP: PRDATA_OUT = {25'h000_0000, maxp_q};
        A_ISO: PRDATA_OUT = 32'(iso_q);
        default: PSLVERR_OUT = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign PREADY_OUT = 1'b1;
  assign TOK_READY_OUT = (st_q == S_IDLE);
  assign TX_VALID_OUT = (st_q == S_TXOUT);
  assign TX_OUT = tx_q;
  assign HS_VALID_OUT = hs_v_q;
  assign HS_CODE_OUT = hs_q;
  // one interrupt through the enable mask
  assign IRQ_OUT = |(intf_all & intm_q);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_stall;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (st_q == S_END && own_q && stall_q) |=> (HS_CODE_OUT == HS_STALL) && HS_VALID_OUT && !eng_we;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not answered cleanly");
  property p_bc;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (st_q == S_WB1 && gnt && !dir_tx) |-> eng_we && eng_wd == {1'b0, cnt_q};
  endproperty
  a_bc: assert property (p_bc) else $error("byte count not written back");
  property p_clip;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (st_q == S_WB1) |-> cnt_q <= maxp_q && maxp_q <= MAXP_LIMIT;
  endproperty
  a_clip: assert property (p_clip) else $error("count beyond max size");
  property p_base;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (eng_we && !apb_ram) |-> ram_a != 8'(desc_q + DESC_BASE);
  endproperty
  a_base: assert property (p_base) else $error("base field written");
  property p_own;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (eng_we && st_q == S_RX) |-> own_q && !stall_q && ram_a[3:0] == cnt_q[3:0];
  endproperty
  a_own: assert property (p_own) else $error("data moved without ownership");
  property p_wb0;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (st_q == S_WB0 && gnt) |-> !eng_wd[OWN_BIT] && eng_wd[5:2] != PID_LAT
      ##1 intf_q[INT_DONE] && st_q == S_IDLE;
  endproperty
  a_wb0: assert property (p_wb0) else $error("write-back or done wrong");
  property p_ovr;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (st_q == S_END && own_q && !stall_q && ovr_q && !dir_tx)
      |=> st_q == S_IDLE && errf_q[ERR_TMO] ##1 !$rose(intf_q[INT_DONE]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun handled wrongly");
  property p_ovs;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (st_q == S_END && own_q && !stall_q && !ovr_q && ovs_q && !dir_tx && !iso)
      |=> HS_CODE_OUT == HS_ACK && errf_q[ERR_OVF] && st_q == S_WB1;
  endproperty
  a_ovs: assert property (p_ovs) else $error("oversize not acked");
  property p_irq;
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    IRQ_OUT |-> |(intm_q & intf_all);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt past the mask");
endmodule

//--- tb/ubde_host_model.sv
// Purpose: host model on the serial side of the descriptor engine
// Assumes: bytes spaced two cycles apart unless back to back is asked for
// Notes: released rx lines carry the inverse of the last byte between bytes, 8'hff after end of packet
module ubde_host_model (
  input wire logic clk_in,
  input wire logic tok_ready_in,
  output logic tok_valid_out,
  output ubde_pkg::ubde_tok_t tok_out,
  output ubde_pkg::ubde_rx_t rx_out,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ubde_pkg::*;
  // --------------------
  // idle levels
  // --------------------
  initial begin
    tok_valid_out = 1'b0;
    tok_out = '0;
    rx_out = '0;
    tx_ready_out = 1'b0;
  end
  // random stalls on the transmit side
  always @(posedge clk_in) begin
    tx_ready_out <= ($urandom % 4) != 0;
  end
  // token held until an edge sees ready high
  task automatic token(input logic [3:0] pid, input logic [2:0] ep, input logic odd);
    @(posedge clk_in);
    tok_valid_out <= 1'b1;
    tok_out <= '{pid, ep, odd};
    @(negedge clk_in);
    while (tok_ready_in !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    tok_valid_out <= 1'b0;
  endtask
  // packets sent whole, then end of packet
  task automatic packet(input int n, input logic [7:0] sd, input logic gap);
    logic [7:0] b;
    repeat (6) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      b = sd + 8'(i * 29);
      rx_out <= '{1'b1, b, 1'b0};
      @(posedge clk_in);
      // without the idle beat the engine has no slack for a stolen port
      if (gap) begin
        // released line must not repeat a stale byte
        rx_out <= '{1'b0, ~b, 1'b0};
        @(posedge clk_in);
      end
    end
    rx_out <= '{1'b1, 8'h00, 1'b1};
    @(posedge clk_in);
    rx_out <= '{1'b0, 8'hff, 1'b0};
  endtask
endmodule

//--- tb/usb_device_buffer_descriptor_engine_tb.sv
// Purpose: self-checking bench for the descriptor engine
// Assumes: zero-wait APB slave, host model on the serial side
// Notes: drivers queue expectations, one monitor compares them
module usb_device_buffer_descriptor_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ubde_pkg::*;
  // --------------------
  // signals and bookkeeping
  // --------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, tok_valid, tok_ready, tx_valid, tx_ready, hs_valid, irq;
  ubde_tok_t tok;
  ubde_rx_t rx;
  ubde_tx_t tx;
  ubde_hs_t hs_code;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int maxp = 64;
  logic [2:0] im = '0;  // mirror of the interrupt mask
  logic [1:0] em = '0;  // mirror of the error mask
  logic [10:0] t;
  logic [32:0] rd_q[$];
  ubde_hs_t hs_q[$];
  logic [10:0] tx_q[$];
  always #2.5 clk = ~clk;
  ubde_top ubde_top_i (
    .CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TOK_VALID_IN(tok_valid), .TOK_IN(tok),
    .TOK_READY_OUT(tok_ready), .RX_IN(rx), .TX_VALID_OUT(tx_valid), .TX_OUT(tx),
    .TX_READY_IN(tx_ready), .HS_VALID_OUT(hs_valid), .HS_CODE_OUT(hs_code), .IRQ_OUT(irq)
  );
  ubde_host_model ubde_host_model_i (
    .clk_in(clk), .tok_ready_in(tok_ready), .tok_valid_out(tok_valid), .tok_out(tok),
    .rx_out(rx), .tx_ready_out(tx_ready)
  );
  // --------------------
  // compare and closing tasks
  // --------------------
  task automatic chk_val(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_hs(input ubde_hs_t got, input ubde_hs_t exp);
    chk_val(33'(got), 33'(exp));
  endtask
  task automatic chk_tx(input logic [9:0] got, input logic [9:0] exp);
    chk_val(33'(got), 33'(exp));
  endtask
  task automatic test_done();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // monitor: oldest note is compared when a result shows
  always @(posedge clk) begin
    if (hs_valid === 1'b1) begin
      chk_hs(hs_code, hs_q.size() ? hs_q.pop_front() : ubde_hs_t'(2'bx));
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      t = tx_q.size() ? tx_q.pop_front() : 11'bx;
      chk_tx({t[10] ? t[9:2] : tx.data, tx.last, tx.zlp}, t[9:0]);
    end
    if (psel && penable && !pwrite && pready === 1'b1) begin
      chk_val({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 33'bx);
    end
  end
  // hang guard, far above the thousand or so cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end
  // --------------------
  // APB master and RAM helpers
  // --------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic ramw(input int i, input logic [7:0] b);
    apb(1'b1, 12'(i * 4), 32'(b));
  endtask
  task automatic ramr(input int i, input logic [7:0] b);
    rd(12'(i * 4), 33'(b));
  endtask
  function automatic logic [7:0] dv(input logic [7:0] s, input int i);
    return s + 8'(i * 29);
  endfunction
  // three bytes per descriptor, ownership byte armed last
  task automatic arm(input int x, input logic [7:0] c, input logic [7:0] n, input logic [7:0] b);
    ramw(x * 3 + 1, n);
    ramw(x * 3 + 2, 8'(b << 2));
    ramw(x * 3, c);
  endtask
  task automatic desc(input int x, input logic [7:0] c, input logic [7:0] n, input logic [7:0] b);
    ramr(x * 3, c);
    ramr(x * 3 + 1, n);
    ramr(x * 3 + 2, 8'(b << 2));
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
    for (int k = 0; k < 400; k++) begin
      if (hs_q.size() == 0 && tok_ready === 1'b1) break;
      @(negedge clk);
    end
  endtask
  // --------------------
  // one token with its checks
  // --------------------
  // firmware arms count, base and ownership before the token
  task automatic run(input logic [2:0] ep, input logic odd, input logic [3:0] pid,
                     input int n, input logic [7:0] base, input logic [7:0] ctrl);
    logic [7:0] sd;
    logic dir, ok, ovf;
    logic [2:0] ie;
    int m, x, a;
    sd = 8'($urandom);
    dir = (pid == PID_IN);
    ok = ctrl[7] && !ctrl[2];
    ovf = !dir && n > maxp;
    m = ovf ? maxp : n;
    x = ep * 4 + dir * 2 + odd;
    a = base * 16;
    for (int i = 0; i <= m; i++) ramw(a + i, dir ? dv(sd, i) : ~dv(sd, i));
    arm(x, ctrl, dir ? 8'(n) : 8'h40, base);
    hs_q.push_back(!ok ? ((ctrl[7] && ctrl[2]) ? HS_STALL : HS_NAK) : (dir ? HS_NONE : HS_ACK));
    // no beat beyond the armed count
    for (int i = 0; ok && dir && (i < n || i == 0); i++) begin
      tx_q.push_back({n == 0, dv(sd, i), i >= n - 1, n == 0});
    end
    ubde_host_model_i.token(pid, ep, odd);
    if (!dir) ubde_host_model_i.packet(n, sd, 1'b1);
    settle();
    if (ok) begin
      for (int i = 0; i <= m; i++) ramr(a + i, (dir || i < m) ? dv(sd, i) : ~dv(sd, i));
      desc(x, {1'b0, ctrl[6], pid, 2'b00}, dir ? 8'(n) : 8'(m), base);
      rd(A_STATUS, 33'({ep, dir, odd}));
    end else begin
      desc(x, ctrl, dir ? 8'(n) : 8'h40, base);
    end
    ie = ok ? {1'b0, ovf & em[1], 1'b1} : {ctrl[7] & ctrl[2], 2'b00};
    rd(A_INTF, 33'(ie));
    rd(A_ERRF, 33'({ovf, 1'b0}));
    @(negedge clk);
    chk_val(33'(irq), 33'(|(ie & im)));
    apb(1'b1, A_INTF, 32'h7);
    apb(1'b1, A_ERRF, 32'h3);
  endtask
  // back-to-back bytes while firmware holds the RAM port
  task automatic run_ovr(input logic [2:0] ep, input logic [7:0] base, input logic iso);
    int x;
    x = ep * 4;
    apb(1'b1, A_ISO, 32'(iso) << ep);
    rd(A_ISO, 33'(iso) << ep);
    arm(x, 8'h80, 8'h40, base);
    hs_q.push_back(iso ? HS_NONE : HS_NAK);
    ubde_host_model_i.token(PID_OUT, ep, 1'b0);
    fork
      ubde_host_model_i.packet(16, 8'($urandom), 1'b0);
      begin
        // access phase lands mid-packet, so one byte finds the holder full
        repeat (8) @(posedge clk);
        ramr(x * 3, 8'h80);
      end
    join
    settle();
    desc(x, 8'h80, 8'h40, base);
    rd(A_INTF, 33'h0);
    rd(A_ERRF, 33'h1);
    apb(1'b1, A_ERRF, 32'h3);
    apb(1'b1, A_ISO, 32'h0);
  endtask
  // --------------------
  // main sequence
  // --------------------
  initial begin
    void'($urandom(17));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(A_MAXP, 33'h40);
    rd(A_INTM, 33'h0);
    rd(A_INTF, 33'h0);
    rd(12'h7f0, 33'h100000000);
    run(3'd1, 1'b0, PID_OUT, 1 + $urandom % 20, 8'd6, 8'hc8);
    im = 3'h7;
    apb(1'b1, A_INTM, 32'h7);
    // endpoint 0 setup buffer of eight bytes
    run(3'd0, 1'b1, PID_SETUP, 8, 8'd8, 8'h88);
    run(3'd0, 1'b1, PID_SETUP, 8, 8'd8, 8'h88);
    run(3'd2, 1'b0, PID_OUT, 4, 8'd10, 8'h84);
    run(3'd2, 1'b1, PID_OUT, 4, 8'd10, 8'h0c);
    run(3'd3, 1'b0, PID_IN, 5, 8'd6, 8'h80);
    run(3'd3, 1'b1, PID_IN, 0, 8'd8, 8'h80);
    apb(1'b1, A_MAXP, 32'h50);
    rd(A_MAXP, 33'h40);
    maxp = 8;
    em = 2'b10;
    apb(1'b1, A_MAXP, 32'h8);
    apb(1'b1, A_ERRM, 32'h2);
    run(3'd1, 1'b1, PID_OUT, 12, 8'd12, 8'h88);
    run_ovr(3'd4, 8'd14, 1'b0);
    run_ovr(3'd5, 8'd14, 1'b1);
    chk_val(33'(hs_q.size() + tx_q.size() + rd_q.size()), 33'h0);
    test_done();
  end
endmodule
